//--- hdl/small_dual_port_ram.sv
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
// Overview of operation
// - Simple dual-port array, one write port, one independent read port.
// - Storage holds exactly 576 bits, parity bits included.
// - Shapes 512x1 to 32x18; the 9 and 18 bit shapes carry parity.
// - Parity bits may be used or left out for any memory type.
// - Works as dual-port RAM, single-port RAM, FIFO, ROM or shift register.
// - RAM or ROM contents preload from an initialization image.
// - Write strobe, data and address registers share one selected clock.
// - Read address, read strobe and output registers take either clock.
// - Read/write mode or input/output mode splits the two clocks.
// - Only the output register can be bypassed; input registers always exist.
// - Input clear resets the input registers at the next clk_sys edge; the output keeps its value.
// - Output clear acts on the data output immediately.
// - Write and read ports may use different widths on the same storage.
module small_dual_port_ram import small_ram_pkg::*; #(
  parameter logic [BITS_TOTAL-1:0] INIT_IMAGE = INIT_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkA,
  input wire logic clkB,
  input wire clk_mode_type clkMode,
  input wire logic clkSwap,
  input wire logic inClkEn,
  input wire logic outClkEn,
  input wire logic inClr,
  input wire logic outClr,
  input wire mem_mode_type memMode,
  input wire shape_type wrShape,
  input wire shape_type rdShape,
  input wire logic parityEn,
  input wire logic outBypass,
  input wire logic rdwOldData,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [1:0] byteEn,
  input wire logic rdEn,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] dataOut,
  output logic fifoFull,
  output logic fifoEmpty
);

  function automatic logic [ADDR_W-1:0] nextPtr(input logic [ADDR_W-1:0] p, input shape_type s);
    logic [BASE_W-1:0] n;
    n = {1'b0, p} + 10'h001;
    return (n >= shapeDepth(s)) ? ADDR_RESET : n[ADDR_W-1:0];
  endfunction : nextPtr

  ////////////////////////////////////////////////////////////////////////////////
  // Clock pins are foreign; two flops then an edge flop
  logic [2:0] syncA_q, syncA_d, syncB_q, syncB_d;
  logic edgeA, edgeB, inSrc, otherSrc;
  logic wrTick, rdInTick, outTick;

  always_comb begin
    syncA_d = {syncA_q[1:0], clkA};
    syncB_d = {syncB_q[1:0], clkB};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      syncA_q <= SYNC_RESET;
      syncB_q <= SYNC_RESET;
    end else begin
      syncA_q <= syncA_d;
      syncB_q <= syncB_d;
    end
  end

  always_comb begin
    edgeA = syncA_q[1] & ~syncA_q[2];
    edgeB = syncB_q[1] & ~syncB_q[2];
    inSrc = clkSwap ? edgeB : edgeA;
    otherSrc = clkSwap ? edgeA : edgeB;
    wrTick = inSrc & inClkEn;
    if (clkMode == CLK_READ_WRITE) begin
      rdInTick = otherSrc & outClkEn;
    end else begin
      rdInTick = inSrc & inClkEn;
    end
    outTick = otherSrc & outClkEn;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input registers, never bypassed
  logic wrEn_q, wrEn_d, wrPulse_q, wrPulse_d, rdEn_q, rdEn_d, rdPulse_q, rdPulse_d;
  logic [ADDR_W-1:0] wrAddr_q, wrAddr_d, rdAddr_q, rdAddr_d;
  logic [DATA_W-1:0] wrData_q, wrData_d;
  logic [1:0] byteEn_q, byteEn_d;

  always_comb begin
    wrEn_d = wrEn_q;
    wrAddr_d = wrAddr_q;
    wrData_d = wrData_q;
    byteEn_d = byteEn_q;
    rdEn_d = rdEn_q;
    rdAddr_d = rdAddr_q;
    wrPulse_d = 1'b0;
    rdPulse_d = 1'b0;
    if (wrTick) begin
      wrEn_d = wrEn;
      wrAddr_d = wrAddr;
      wrData_d = wrData;
      byteEn_d = byteEn;
      wrPulse_d = 1'b1;
    end
    if (rdInTick) begin
      rdEn_d = rdEn;
      rdAddr_d = rdAddr;
      rdPulse_d = 1'b1;
    end
    if (inClr) begin
      wrEn_d = 1'b0;
      wrAddr_d = ADDR_RESET;
      wrData_d = DATA_RESET;
      byteEn_d = 2'h0;
      rdEn_d = 1'b0;
      rdAddr_d = ADDR_RESET;
      wrPulse_d = 1'b0;
      rdPulse_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrEn_q <= 1'b0;
      wrAddr_q <= ADDR_RESET;
      wrData_q <= DATA_RESET;
      byteEn_q <= 2'h0;
      rdEn_q <= 1'b0;
      rdAddr_q <= ADDR_RESET;
      wrPulse_q <= 1'b0;
      rdPulse_q <= 1'b0;
    end else begin
      wrEn_q <= wrEn_d;
      wrAddr_q <= wrAddr_d;
      wrData_q <= wrData_d;
      byteEn_q <= byteEn_d;
      rdEn_q <= rdEn_d;
      rdAddr_q <= rdAddr_d;
      wrPulse_q <= wrPulse_d;
      rdPulse_q <= rdPulse_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode steering; FIFO assumes equal port shapes
  logic [ADDR_W-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d, wrWord, rdWord;
  logic [BASE_W-1:0] fifoCount_q, fifoCount_d, wrBase, rdBase;
  logic doWrite, doRead, isFifo, rdwHit;
  logic [DATA_W-1:0] wrMask, arrayData;

  always_comb begin
    isFifo = (memMode == MODE_FIFO);
    fifoFull = isFifo && (fifoCount_q == shapeDepth(wrShape));
    fifoEmpty = isFifo && (fifoCount_q == COUNT_RESET);
    doWrite = wrPulse_q && wrEn_q && (memMode != MODE_ROM) && !fifoFull;
    doRead = rdPulse_q && rdEn_q && !fifoEmpty;
    case (memMode)
      MODE_FIFO: begin
        wrWord = wrPtr_q;
        rdWord = rdPtr_q;
      end
      MODE_SHIFT: begin
        wrWord = wrPtr_q;
        rdWord = wrPtr_q;
      end
      MODE_SINGLE_PORT: begin
        wrWord = wrAddr_q;
        rdWord = wrAddr_q;
      end
      default: begin
        wrWord = wrAddr_q;
        rdWord = rdAddr_q;
      end
    endcase
    wrBase = wordBase(wrWord, wrShape);
    rdBase = wordBase(rdWord, rdShape);
    wrMask = widthMask(wrShape, parityEn) & laneMask(wrShape, byteEn_q);
    rdwHit = doWrite && doRead
      && (11'(wrBase) < 11'(rdBase) + 11'(shapeWidth(rdShape)))
      && (11'(rdBase) < 11'(wrBase) + 11'(shapeWidth(wrShape)));
  end

  always_comb begin
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    fifoCount_d = fifoCount_q;
    if (doWrite && (isFifo || memMode == MODE_SHIFT)) begin
      wrPtr_d = nextPtr(wrPtr_q, wrShape);
    end
    if (doRead && isFifo) begin
      rdPtr_d = nextPtr(rdPtr_q, rdShape);
    end
    if (isFifo && doWrite && !doRead) begin
      fifoCount_d = fifoCount_q + 10'h001;
    end else if (isFifo && doRead && !doWrite) begin
      fifoCount_d = fifoCount_q - 10'h001;
    end
  end

  // Pointers survive the clears so a FIFO keeps its contents
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr_q <= ADDR_RESET;
      rdPtr_q <= ADDR_RESET;
      fifoCount_q <= COUNT_RESET;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      fifoCount_q <= fifoCount_d;
    end
  end

  small_ram_array #(
    .INIT_IMAGE(INIT_IMAGE)
  ) i_small_ram_array (
    .clk_sys(clk_sys),
    .rst(rst),
    .wrPulse(doWrite),
    .wrBase(wrBase),
    .wrMask(wrMask),
    .wrData(wrData_q),
    .rdBase(rdBase),
    .rdData(arrayData)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read word and output register; clears leave the array alone
  logic [DATA_W-1:0] rdWord_q, rdWord_d, dataOut_q, dataOut_d, rdMask;

  always_comb begin
    rdMask = widthMask(rdShape, parityEn);
    rdWord_d = rdWord_q;
    if (doRead) begin
      if (rdwHit && !rdwOldData) begin
        rdWord_d = UNDEF_WORD & rdMask;
      end else begin
        rdWord_d = arrayData & rdMask;
      end
    end
    dataOut_d = dataOut_q;
    if (outTick) begin
      dataOut_d = rdWord_q;
    end
    if (outClr) begin
      dataOut_d = OUT_RESET;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdWord_q <= OUT_RESET;
      dataOut_q <= OUT_RESET;
    end else begin
      rdWord_q <= rdWord_d;
      dataOut_q <= dataOut_d;
    end
  end

  // Clear gates the pin directly since it must not wait for an edge
  always_comb begin
    if (outClr) begin
      dataOut = OUT_RESET;
    end else if (outBypass) begin
      dataOut = rdWord_q;
    end else begin
      dataOut = dataOut_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_out_clear_now: assert property (outClr |-> dataOut == OUT_RESET)
    else $error("output clear not seen at once");
  a_in_clear_regs: assert property (inClr |=> !wrPulse_q && !rdPulse_q && !wrEn_q)
    else $error("input registers not cleared");
  a_clear_late_out: assert property (inClr && !doRead |=> $stable(rdWord_q))
    else $error("read word moved without a read");
  a_rom_no_write: assert property (memMode == MODE_ROM |-> !doWrite)
    else $error("write reached array in ROM mode");
  a_wr_capture: assert property (wrTick && !inClr |=> wrPulse_q && wrAddr_q == $past(wrAddr))
    else $error("write port not captured on its tick");
  a_rd_capture: assert property (rdInTick && !inClr |=> rdPulse_q && rdAddr_q == $past(rdAddr))
    else $error("read address not captured on its tick");
  a_io_mode_ticks: assert property (clkMode == CLK_INPUT_OUTPUT |-> rdInTick == wrTick)
    else $error("input registers split in input/output mode");
  a_out_reg_load: assert property (outTick && !outClr |=> dataOut_q == $past(rdWord_q))
    else $error("output register missed its tick");
  a_bypass_path: assert property (outBypass && !outClr |-> dataOut == rdWord_q)
    else $error("bypass did not pass read word");
  a_rdw_undef: assert property (doRead && rdwHit && !rdwOldData |=>
    rdWord_q == (UNDEF_WORD & $past(rdMask)))
    else $error("collision did not give undefined word");
  a_parity_off: assert property (hasParity(wrShape) && !parityEn |-> !wrMask[PARITY_LO])
    else $error("parity bit written with parity off");
  a_fifo_bound: assert property (isFifo |-> fifoCount_q <= shapeDepth(wrShape))
    else $error("fifo count beyond depth");

  c_fifo_full: cover property (fifoFull);
  c_rdw_hit: cover property (rdwHit);
  c_out_clear: cover property (outClr && outTick);
  c_shift_write: cover property (memMode == MODE_SHIFT && doWrite && doRead);

endmodule : small_dual_port_ram

//--- hdl/small_ram_pkg.sv
package small_ram_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Array geometry
  localparam int BITS_TOTAL = 576;
  localparam int DATA_W = 18;
  localparam int ADDR_W = 9;
  localparam int BASE_W = 10;
  localparam int LANE_COUNT = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset and fill values
  localparam logic [DATA_W-1:0] OUT_RESET = 18'h00000;
  localparam logic [DATA_W-1:0] UNDEF_WORD = 18'h2aaaa;
  localparam logic [BITS_TOTAL-1:0] INIT_DEFAULT = 576'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
  localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;
  localparam logic [BASE_W-1:0] COUNT_RESET = 10'h000;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions of the parity bits and of the byte lane split inside a word
  localparam int PARITY_LO = 8;
  localparam int PARITY_HI = 17;
  localparam logic [4:0] LANE_PLAIN = 5'h08;
  localparam logic [4:0] LANE_PARITY = 5'h09;

  typedef enum logic [2:0] {
    SHAPE_512X1, SHAPE_256X2, SHAPE_128X4, SHAPE_64X8, SHAPE_64X9, SHAPE_32X16, SHAPE_32X18
  } shape_type;

  typedef enum logic [2:0] {
    MODE_SIMPLE_DUAL, MODE_SINGLE_PORT, MODE_FIFO, MODE_ROM, MODE_SHIFT
  } mem_mode_type;

  typedef enum logic {CLK_READ_WRITE, CLK_INPUT_OUTPUT} clk_mode_type;

  function automatic logic [4:0] shapeWidth(input shape_type s);
    case (s)
      SHAPE_512X1: return 5'h01;
      SHAPE_256X2: return 5'h02;
      SHAPE_128X4: return 5'h04;
      SHAPE_64X8: return 5'h08;
      SHAPE_64X9: return 5'h09;
      SHAPE_32X16: return 5'h10;
      default: return 5'h12;
    endcase
  endfunction : shapeWidth

  function automatic logic [9:0] shapeDepth(input shape_type s);
    case (s)
      SHAPE_512X1: return 10'h200;
      SHAPE_256X2: return 10'h100;
      SHAPE_128X4: return 10'h080;
      SHAPE_64X8, SHAPE_64X9: return 10'h040;
      default: return 10'h020;
    endcase
  endfunction : shapeDepth

  function automatic logic hasParity(input shape_type s);
    return (s == SHAPE_64X9) || (s == SHAPE_32X18);
  endfunction : hasParity

  // First array bit of a word; the address wraps at the depth of the shape
  function automatic logic [BASE_W-1:0] wordBase(input logic [ADDR_W-1:0] a, input shape_type s);
    logic [13:0] prod;
    logic [ADDR_W-1:0] lim;
    lim = ADDR_W'(shapeDepth(s) - 10'h001);
    prod = 14'(a & lim) * 14'(shapeWidth(s));
    return prod[BASE_W-1:0];
  endfunction : wordBase

  // Bits of a word that carry data; parity bits drop out when parity is off
  function automatic logic [DATA_W-1:0] widthMask(input shape_type s, input logic parOn);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W; i++) begin
      m[i] = (i < int'(shapeWidth(s)));
    end
    if (hasParity(s) && !parOn) begin
      m[PARITY_LO] = 1'b0;
      m[PARITY_HI] = 1'b0;
    end
    return m;
  endfunction : widthMask

  function automatic logic [DATA_W-1:0] laneMask(input shape_type s, input logic [1:0] be);
    logic [DATA_W-1:0] m;
    logic [4:0] lw;
    m = '0;
    lw = hasParity(s) ? LANE_PARITY : LANE_PLAIN;
    for (int i = 0; i < DATA_W; i++) begin
      m[i] = (i < int'(lw)) ? be[0] : be[1];
    end
    return m;
  endfunction : laneMask

endpackage : small_ram_pkg

//--- hdl/small_ram_array.sv
`timescale 1ns/1ns
module small_ram_array import small_ram_pkg::*; #(
  parameter logic [BITS_TOTAL-1:0] INIT_IMAGE = INIT_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wrPulse,
  input wire logic [BASE_W-1:0] wrBase,
  input wire logic [DATA_W-1:0] wrMask,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [BASE_W-1:0] rdBase,
  output logic [DATA_W-1:0] rdData
);

  logic [BITS_TOTAL-1:0] bits_q;
  logic [BITS_TOTAL-1:0] bits_d;

  ////////////////////////////////////////////////////////////////////////////////
  // One flat bit array lets mixed port widths share the storage
  always_comb begin
    bits_d = bits_q;
    if (wrPulse) begin
      for (int i = 0; i < DATA_W; i++) begin
        if (wrMask[i] && (int'(wrBase) + i) < BITS_TOTAL) begin
          bits_d[int'(wrBase) + i] = wrData[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bits_q <= INIT_IMAGE;
    end else begin
      bits_q <= bits_d;
    end
  end

  // Read before the pending write lands, so a same-edge read sees old data
  always_comb begin
    rdData = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if ((int'(rdBase) + i) < BITS_TOTAL) begin
        rdData[i] = bits_q[int'(rdBase) + i];
      end
    end
  end

endmodule : small_ram_array

//--- verif/clock_pin_driver.sv
`timescale 1ns/1ns
module clock_pin_driver (
  input wire logic clk_sys,
  output logic clkA,
  output logic clkB
);
  ////////////////////////////////////////////////////////////////////////////////
  // Neighbouring user logic toggling the memory clock pins as plain signals
  initial begin
    clkA = 1'b0;
    clkB = 1'b0;
  end

  // Pins stand low between pulses; len of at least 2 keeps the synchroniser happy
  task automatic pulse(input logic sel, input int len);
    @(posedge clk_sys);
    if (sel) begin
      clkB <= 1'b1;
    end else begin
      clkA <= 1'b1;
    end
    repeat (len) @(posedge clk_sys);
    clkA <= 1'b0;
    clkB <= 1'b0;
    repeat (len) @(posedge clk_sys);
  endtask : pulse
endmodule : clock_pin_driver

//--- verif/test_small_dual_port_ram.sv
`timescale 1ns/1ns
module test_small_dual_port_ram import small_ram_pkg::*; ;
  localparam logic [DATA_W-1:0] INIT_WORD = 18'h12345;
  localparam logic [DATA_W-1:0] TOP_WORD = 18'h3ffff;
  localparam logic [BITS_TOTAL-1:0] INIT_PAT = {TOP_WORD, {31{INIT_WORD}}};
  int widths [7] = '{1, 2, 4, 8, 9, 16, 18};
  int depths [7] = '{512, 256, 128, 64, 64, 32, 32};
  logic clk_sys, rst, clkA, clkB, clkSwap, inClkEn, outClkEn, inClr, outClr;
  logic parityEn, outBypass, rdwOldData, wrEn, rdEn, fifoFull, fifoEmpty;
  clk_mode_type clkMode;
  mem_mode_type memMode;
  shape_type wrShape, rdShape;
  logic [ADDR_W-1:0] wrAddr, rdAddr;
  logic [DATA_W-1:0] wrData, dataOut;
  logic [1:0] byteEn;
  int errCount, samplesChecked;

  ////////////////////////////////////////////////////////////////////////////////
  small_dual_port_ram #(.INIT_IMAGE(INIT_PAT)) i_small_dual_port_ram (
    .clk_sys(clk_sys), .rst(rst), .clkA(clkA), .clkB(clkB), .clkMode(clkMode),
    .clkSwap(clkSwap), .inClkEn(inClkEn), .outClkEn(outClkEn), .inClr(inClr),
    .outClr(outClr), .memMode(memMode), .wrShape(wrShape), .rdShape(rdShape),
    .parityEn(parityEn), .outBypass(outBypass), .rdwOldData(rdwOldData), .wrEn(wrEn),
    .wrAddr(wrAddr), .wrData(wrData), .byteEn(byteEn), .rdEn(rdEn), .rdAddr(rdAddr),
    .dataOut(dataOut), .fifoFull(fifoFull), .fifoEmpty(fifoEmpty)
  );

  clock_pin_driver i_clock_pin_driver (.clk_sys(clk_sys), .clkA(clkA), .clkB(clkB));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
    samplesChecked++;
    if (seen !== want) begin
      errCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  // Inputs stay put for the whole pin pulse, so the late synchronised tick sees them
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic [1:0] be);
    wrEn <= 1'b1;
    wrAddr <= a;
    wrData <= d;
    byteEn <= be;
    i_clock_pin_driver.pulse(clkSwap, 3);
    wrEn <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] want);
    rdEn <= 1'b1;
    rdAddr <= a;
    i_clock_pin_driver.pulse(clkMode == CLK_INPUT_OUTPUT ? clkSwap : !clkSwap, 3);
    rdEn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check(dataOut, want);
    @(posedge clk_sys);
  endtask : rd

  task automatic finishTest();
    $display("comparisons %0d, mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finishTest

  initial begin
    #400000;
    errCount++;
    $display("run stopped by watchdog");
    finishTest();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    clkMode = CLK_READ_WRITE;
    clkSwap = 1'b0;
    inClkEn = 1'b1;
    outClkEn = 1'b1;
    inClr = 1'b0;
    outClr = 1'b0;
    memMode = MODE_ROM;
    wrShape = SHAPE_32X18;
    rdShape = SHAPE_32X18;
    parityEn = 1'b1;
    outBypass = 1'b1;
    rdwOldData = 1'b1;
    wrEn = 1'b0;
    wrAddr = 9'h000;
    wrData = 18'h00000;
    byteEn = 2'h3;
    rdEn = 1'b0;
    rdAddr = 9'h000;
    errCount = 0;
    samplesChecked = 0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    check(dataOut, 18'h00000);
    @(posedge clk_sys);
    wr(9'h002, 18'h3ffff, 2'h3);
    rd(9'h002, INIT_WORD);
    rd(9'h01f, TOP_WORD);
    rd(9'h020, INIT_WORD);
    $display("test preload done");

    memMode <= MODE_SIMPLE_DUAL;
    for (int s = 0; s < 7; s++) begin
      wrShape <= shape_type'(s);
      rdShape <= shape_type'(s);
      wr(ADDR_W'(depths[s] - 1), 18'h2b5a5, 2'h3);
      rd(ADDR_W'(depths[s] - 1), DATA_W'((19'h00001 << widths[s]) - 19'h00001) & 18'h2b5a5);
    end
    wrShape <= SHAPE_64X9;
    rdShape <= SHAPE_64X9;
    parityEn <= 1'b0;
    wr(9'h003, 18'h001ff, 2'h3);
    rd(9'h003, 18'h000ff);
    parityEn <= 1'b1;
    rd(9'h003, 18'h000ff);
    $display("test shapes done");

    // An 8 bit word spans two 4 bit words of the same storage
    wrShape <= SHAPE_64X8;
    rdShape <= SHAPE_128X4;
    wr(9'h001, 18'h000a5, 2'h3);
    rd(9'h002, 18'h00005);
    rd(9'h003, 18'h0000a);
    wrShape <= SHAPE_32X16;
    rdShape <= SHAPE_32X16;
    wr(9'h004, 18'h0ffff, 2'h3);
    wr(9'h004, 18'h01234, 2'h1);
    rd(9'h004, 18'h0ff34);
    wr(9'h004, 18'h05678, 2'h2);
    rd(9'h004, 18'h05634);
    $display("test widths and lanes done");

    clkSwap <= 1'b1;
    @(posedge clk_sys);
    wr(9'h005, 18'h0abcd, 2'h3);
    rd(9'h005, 18'h0abcd);
    clkSwap <= 1'b0;
    clkMode <= CLK_INPUT_OUTPUT;
    @(posedge clk_sys);
    wr(9'h006, 18'h0beef, 2'h3);
    inClkEn <= 1'b0;
    wr(9'h006, 18'h00000, 2'h3);
    inClkEn <= 1'b1;
    rd(9'h006, 18'h0beef);
    $display("test clocking done");

    // Registered output lags the read word by one output tick
    clkMode <= CLK_READ_WRITE;
    outBypass <= 1'b0;
    outClr <= 1'b1;
    @(negedge clk_sys);
    check(dataOut, 18'h00000);
    @(posedge clk_sys);
    outClr <= 1'b0;
    wr(9'h007, 18'h01111, 2'h3);
    rd(9'h007, 18'h0beef);
    outClkEn <= 1'b0;
    i_clock_pin_driver.pulse(1'b1, 5);
    @(negedge clk_sys);
    check(dataOut, 18'h0beef);
    @(posedge clk_sys);
    outClkEn <= 1'b1;
    i_clock_pin_driver.pulse(1'b1, 5);
    @(negedge clk_sys);
    check(dataOut, 18'h01111);
    @(posedge clk_sys);
    inClr <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check(dataOut, 18'h01111);
    @(posedge clk_sys);
    inClr <= 1'b0;
    $display("test output register done");

    // Single-port mode reads at the held write address; one input tick both writes and reads a word when both ports share the clock
    outBypass <= 1'b1;
    memMode <= MODE_SINGLE_PORT;
    wr(9'h008, 18'h0cafe, 2'h3);
    rd(9'h000, 18'h0cafe);
    memMode <= MODE_SIMPLE_DUAL;
    clkMode <= CLK_INPUT_OUTPUT;
    rdwOldData <= 1'b0;
    rdEn <= 1'b1;
    rdAddr <= 9'h009;
    wr(9'h009, 18'h01111, 2'h3);
    @(negedge clk_sys);
    check(dataOut, UNDEF_WORD & 18'h0ffff);
    @(posedge clk_sys);
    rdwOldData <= 1'b1;
    wr(9'h009, 18'h02222, 2'h3);
    @(negedge clk_sys);
    check(dataOut, 18'h01111);
    @(posedge clk_sys);
    rdEn <= 1'b0;
    clkMode <= CLK_READ_WRITE;
    $display("test port modes done");

    outBypass <= 1'b1;
    memMode <= MODE_FIFO;
    wrShape <= SHAPE_32X18;
    rdShape <= SHAPE_32X18;
    @(negedge clk_sys);
    check({17'h00000, fifoEmpty}, 18'h00001);
    @(posedge clk_sys);
    for (int i = 0; i < 33; i++) begin
      wr(9'h000, DATA_W'(i * 3), 2'h3);
    end
    @(negedge clk_sys);
    check({17'h00000, fifoFull}, 18'h00001);
    @(posedge clk_sys);
    for (int i = 0; i < 32; i++) begin
      rd(9'h000, DATA_W'(i * 3));
    end
    @(negedge clk_sys);
    check({17'h00000, fifoEmpty}, 18'h00001);
    @(posedge clk_sys);
    $display("test fifo done");

    // Pointer wrapped after the fifo pass, so the shift read returns the second fifo word
    memMode <= MODE_SHIFT;
    clkMode <= CLK_INPUT_OUTPUT;
    rdEn <= 1'b1;
    wr(9'h000, 18'h00077, 2'h3);
    wr(9'h000, 18'h00088, 2'h3);
    @(negedge clk_sys);
    check(dataOut, 18'h00003);
    @(posedge clk_sys);
    rdEn <= 1'b0;
    $display("test shift done");
    finishTest();
  end
endmodule : test_small_dual_port_ram
